/* design/md_decode.sv */
// Multiply, divide, BCD adjust, sign extend, shift and logic opcode decoder
//
// Summary of operation
// - Group opcode with reg 101 is signed product, 25-28/34-37, memory up to 43.
// - Immediate signed product into reg; second immediate byte only when s is 0.
// - Group opcode reg 110 unsigned quotient: 29, 38, 35, 44 cycles.
// - Group opcode reg 111 signed quotient: 44-52, 53-61, 50-58, 59-67 cycles.
// - Byte pair d4 0a adjusts after byte product in 19 cycles.
// - Byte pair d5 0a adjusts before byte quotient in 15 cycles.
// - Byte sign extension into accumulator in 2 cycles.
// - Accumulator sign extension into register pair in 4 cycles.
// - Shift by one, by count register, or by trailing count byte, with cycle costs.
// - Operation field of shift opcodes selects rotate or shift kind.
// - Conjunction: reg/mem form, immediate group form reg 100, accumulator form.
// - Test updates flags only in reg/mem and group reg 000 forms; the accumulator form keeps stores set.
// - Disjunction: reg/mem form, immediate group form reg 001, accumulator form.
// - Logic immediates fetch a second data byte only for word operands.
// - Narrow bus: word operations other than shifts and immediate product add 4 cycles per memory transfer.
`timescale 1ns/100ps
`default_nettype none

module md_decode (
  input wire logic clock,
  input wire logic rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [7:0] shift_count_register,
  input wire logic narrow_bus,
  output logic byte_ready,
  output md_pkg::md_dec_t decoded,
  output logic exec_busy,
  output logic exec_done,
  output logic not_mine
);

  // ************************************************************
  // Types, state and helpers
  // ************************************************************
  typedef enum {
    ST_IDLE, ST_SECOND, ST_MODRM, ST_IMM_LO, ST_IMM_HI, ST_COUNT, ST_LOOKUP, ST_EXEC
  } md_state_t;

  md_state_t state, next_state;
  md_pkg::md_dec_t next_decoded;
  logic [md_pkg::MD_NW-1:0] remain, next_remain;
  logic next_byte_ready, next_exec_busy, next_exec_done, next_not_mine;
  logic bus_meta, bus_sync;
  logic take;
  logic [md_pkg::MD_CW-1:0] base_cycles;
  logic [md_pkg::MD_NW-1:0] extra;

  // First-byte classification; group opcodes still wait for their ModRM
  function automatic md_pkg::md_kind_t first_kind(input logic [7:0] op);
    md_pkg::md_kind_t k;
    k = md_pkg::MD_K_NONE;
    casez (op)
      md_pkg::MD_OP_GRP3: k = md_pkg::MD_K_GRP3;
      md_pkg::MD_OP_SIGNED_PRODUCT_IMM: k = md_pkg::MD_K_SIGNED_PRODUCT_IMM;
      md_pkg::MD_OP_AAM: k = md_pkg::MD_K_AAM;
      md_pkg::MD_OP_AAD: k = md_pkg::MD_K_AAD;
      md_pkg::MD_OP_CBW: k = md_pkg::MD_K_CBW;
      md_pkg::MD_OP_CWD: k = md_pkg::MD_K_CWD;
      md_pkg::MD_OP_SH1: k = md_pkg::MD_K_SH1;
      md_pkg::MD_OP_SHCL: k = md_pkg::MD_K_SHCL;
      md_pkg::MD_OP_SHCNT: k = md_pkg::MD_K_SHCNT;
      md_pkg::MD_OP_AND_RM: k = md_pkg::MD_K_AND_RM;
      md_pkg::MD_OP_GRP1: k = md_pkg::MD_K_GRP1;
      md_pkg::MD_OP_AND_ACC: k = md_pkg::MD_K_AND_ACC;
      md_pkg::MD_OP_TEST_RM: k = md_pkg::MD_K_TEST_RM;
      md_pkg::MD_OP_TEST_ACC: k = md_pkg::MD_K_TEST_ACC;
      md_pkg::MD_OP_OR_RM: k = md_pkg::MD_K_OR_RM;
      md_pkg::MD_OP_OR_ACC: k = md_pkg::MD_K_OR_ACC;
      default: k = md_pkg::MD_K_NONE;
    endcase
    return k;
  endfunction

  // Kinds whose first byte is followed by a ModRM byte
  function automatic logic wants_modrm(input md_pkg::md_kind_t k);
    case (k)
      md_pkg::MD_K_GRP3, md_pkg::MD_K_GRP1, md_pkg::MD_K_SIGNED_PRODUCT_IMM,
      md_pkg::MD_K_SH1, md_pkg::MD_K_SHCL, md_pkg::MD_K_SHCNT,
      md_pkg::MD_K_AND_RM, md_pkg::MD_K_TEST_RM, md_pkg::MD_K_OR_RM: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Kinds that carry immediate data after the opcode or ModRM
  function automatic logic wants_imm(input md_pkg::md_kind_t k);
    case (k)
      md_pkg::MD_K_SIGNED_PRODUCT_IMM, md_pkg::MD_K_AND_IMM, md_pkg::MD_K_OR_IMM,
      md_pkg::MD_K_TEST_IMM, md_pkg::MD_K_AND_ACC, md_pkg::MD_K_OR_ACC,
      md_pkg::MD_K_TEST_ACC: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Where to go once opcode and ModRM are known
  function automatic md_state_t after_modrm(input md_pkg::md_kind_t k);
    if (k == md_pkg::MD_K_SHCNT) begin
      return ST_COUNT;
    end else if (wants_imm(k)) begin
      return ST_IMM_LO;
    end
    return ST_LOOKUP;
  endfunction

  // ************************************************************
  // Narrow-bus strap arrives from a pin: two-stage synchroniser
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      bus_meta <= 1'b0;
      bus_sync <= 1'b0;
    end else begin
      bus_meta <= narrow_bus;
      bus_sync <= bus_meta;
    end
  end

  md_cycle_rom u_rom (
    .clock(clock),
    .rst(rst),
    .kind(next_decoded.kind),
    .mem(next_decoded.mem),
    .word(next_decoded.word),
    .base_cycles(base_cycles)
  );

  // ************************************************************
  // Cycle extras: shift count and narrow-bus word penalty
  // ************************************************************
  always_comb begin
    extra = '0;
    if (decoded.kind == md_pkg::MD_K_SHCL || decoded.kind == md_pkg::MD_K_SHCNT) begin
      extra = {{(md_pkg::MD_NW-8){1'b0}}, decoded.shift_n};
    end
    // Only the starred (bus-sensitive) entries pay the narrow-bus penalty
    if (bus_sync && decoded.word && decoded.mem &&
        decoded.kind != md_pkg::MD_K_SIGNED_PRODUCT_IMM && decoded.kind != md_pkg::MD_K_SH1 &&
        decoded.kind != md_pkg::MD_K_SHCL && decoded.kind != md_pkg::MD_K_SHCNT) begin
      extra = extra + {{(md_pkg::MD_NW-md_pkg::MD_CW){1'b0}}, md_pkg::MD_CYC_NARROW_BUS};
      // A stored memory result is a second transfer; products and quotients land in registers
      if (decoded.stores && !decoded.dir && decoded.kind != md_pkg::MD_K_SMUL &&
          decoded.kind != md_pkg::MD_K_UQUOT && decoded.kind != md_pkg::MD_K_SQUOT) begin
        extra = extra + {{(md_pkg::MD_NW-md_pkg::MD_CW){1'b0}}, md_pkg::MD_CYC_NARROW_BUS};
      end
    end
  end

  // ************************************************************
  // Fetch and execute sequence
  // ************************************************************
  assign take = byte_valid && byte_ready;

  always_comb begin
    next_state = state;
    next_decoded = decoded;
    next_remain = remain;
    next_exec_done = 1'b0;
    next_not_mine = 1'b0;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_decoded = '0;
          next_decoded.kind = first_kind(byte_data);
          next_decoded.word = byte_data[md_pkg::MD_W_BIT];
          next_decoded.dir = byte_data[md_pkg::MD_D_BIT];
          next_decoded.stores = 1'b1;
          case (next_decoded.kind)
            md_pkg::MD_K_NONE: next_not_mine = 1'b1;
            md_pkg::MD_K_AAM, md_pkg::MD_K_AAD: next_state = ST_SECOND;
            md_pkg::MD_K_CBW, md_pkg::MD_K_CWD: next_state = ST_LOOKUP;
            default: begin
              if (wants_modrm(next_decoded.kind)) begin
                next_state = ST_MODRM;
              end else begin
                next_state = ST_IMM_LO;
              end
            end
          endcase
          // Immediate product: reg field is destination, s bit is not a direction
          if (next_decoded.kind == md_pkg::MD_K_SIGNED_PRODUCT_IMM) begin
            next_decoded.word = 1'b1;
            next_decoded.dir = 1'b1;
          end
          if (next_decoded.kind == md_pkg::MD_K_SIGNED_PRODUCT_IMM ||
              next_decoded.kind == md_pkg::MD_K_TEST_RM || next_decoded.kind ==
              md_pkg::MD_K_GRP3 || next_decoded.kind == md_pkg::MD_K_SH1 ||
              next_decoded.kind == md_pkg::MD_K_SHCL || next_decoded.kind ==
              md_pkg::MD_K_SHCNT || next_decoded.kind == md_pkg::MD_K_GRP1) begin
            // The s bit of the immediate product must survive for the fetch length
            next_decoded.dir = (next_decoded.kind == md_pkg::MD_K_SIGNED_PRODUCT_IMM) ?
                               byte_data[md_pkg::MD_S_BIT] : 1'b0;
          end
        end
      end
      ST_SECOND: begin
        if (take) begin
          if (byte_data == md_pkg::MD_OP_BCD_BASE) begin
            next_state = ST_LOOKUP;
          end else begin
            next_not_mine = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          next_decoded.mode = byte_data[md_pkg::MD_MOD_HI:md_pkg::MD_MOD_LO];
          next_decoded.reg_f = byte_data[md_pkg::MD_REG_HI:md_pkg::MD_REG_LO];
          next_decoded.rm = byte_data[md_pkg::MD_RM_HI:0];
          next_decoded.mem = next_decoded.mode != md_pkg::MD_MOD_REG;
          next_decoded.shift_op_select = md_pkg::md_shift_t'(next_decoded.reg_f);
          if (decoded.kind == md_pkg::MD_K_SH1) begin
            next_decoded.shift_n = 8'h01;
          end else if (decoded.kind == md_pkg::MD_K_SHCL) begin
            next_decoded.shift_n = shift_count_register;
          end
          if (decoded.kind == md_pkg::MD_K_GRP3) begin
            case (next_decoded.reg_f)
              md_pkg::MD_G3_TEST: next_decoded.kind = md_pkg::MD_K_TEST_IMM;
              md_pkg::MD_G3_SMUL: next_decoded.kind = md_pkg::MD_K_SMUL;
              md_pkg::MD_G3_UQUOT: next_decoded.kind = md_pkg::MD_K_UQUOT;
              md_pkg::MD_G3_SQUOT: next_decoded.kind = md_pkg::MD_K_SQUOT;
              default: next_decoded.kind = md_pkg::MD_K_NONE;
            endcase
          end else if (decoded.kind == md_pkg::MD_K_GRP1) begin
            case (next_decoded.reg_f)
              md_pkg::MD_G1_AND: next_decoded.kind = md_pkg::MD_K_AND_IMM;
              md_pkg::MD_G1_OR: next_decoded.kind = md_pkg::MD_K_OR_IMM;
              default: next_decoded.kind = md_pkg::MD_K_NONE;
            endcase
          end
          // Test reg/mem and test immediate forms never write back
          if (next_decoded.kind == md_pkg::MD_K_TEST_IMM ||
              next_decoded.kind == md_pkg::MD_K_TEST_RM) begin
            next_decoded.stores = 1'b0;
          end
          if (next_decoded.kind == md_pkg::MD_K_NONE) begin
            next_not_mine = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_state = after_modrm(next_decoded.kind);
          end
        end
      end
      ST_IMM_LO: begin
        if (take) begin
          next_decoded.imm = {{8{byte_data[7]}}, byte_data};
          if (decoded.kind == md_pkg::MD_K_SIGNED_PRODUCT_IMM) begin
            next_state = decoded.dir ? ST_LOOKUP : ST_IMM_HI;
          end else begin
            next_state = decoded.word ? ST_IMM_HI : ST_LOOKUP;
          end
        end
      end
      ST_IMM_HI: begin
        if (take) begin
          next_decoded.imm = {byte_data, decoded.imm[7:0]};
          next_state = ST_LOOKUP;
        end
      end
      ST_COUNT: begin
        if (take) begin
          next_decoded.shift_n = byte_data;
          next_state = ST_LOOKUP;
        end
      end
      ST_LOOKUP: begin
        // The table registered the kind as it settled, so its answer stands here
        next_state = ST_EXEC;
        next_remain = {{(md_pkg::MD_NW-md_pkg::MD_CW){1'b0}}, base_cycles} + extra;
      end
      ST_EXEC: begin
        next_remain = remain - {{(md_pkg::MD_NW-1){1'b0}}, 1'b1};
        if (remain == {{(md_pkg::MD_NW-1){1'b0}}, 1'b1}) begin
          next_exec_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_exec_busy = next_state == ST_EXEC;
    next_byte_ready = next_state != ST_LOOKUP && next_state != ST_EXEC;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      decoded <= '0;
      remain <= '0;
      byte_ready <= 1'b0;
      exec_busy <= 1'b0;
      exec_done <= 1'b0;
      not_mine <= 1'b0;
    end else begin
      state <= next_state;
      decoded <= next_decoded;
      remain <= next_remain;
      byte_ready <= next_byte_ready;
      exec_busy <= next_exec_busy;
      exec_done <= next_exec_done;
      not_mine <= next_not_mine;
    end
  end

endmodule

`default_nettype wire

/* pkg/md_pkg.sv */
// Shared constants, opcode patterns, cycle tables and types of the decoder
package md_pkg;

  // ************************************************************
  // Opcode patterns (binary keeps the w, d and s bits visible)
  // ************************************************************
  localparam logic [7:0] MD_OP_GRP3 = 8'b1111_011?;
  localparam logic [7:0] MD_OP_SIGNED_PRODUCT_IMM = 8'b0110_10?1;
  localparam logic [7:0] MD_OP_AAM = 8'hd4;
  localparam logic [7:0] MD_OP_AAD = 8'hd5;
  localparam logic [7:0] MD_OP_BCD_BASE = 8'h0a;
  localparam logic [7:0] MD_OP_CBW = 8'h98;
  localparam logic [7:0] MD_OP_CWD = 8'h99;
  localparam logic [7:0] MD_OP_SH1 = 8'b1101_000?;
  localparam logic [7:0] MD_OP_SHCL = 8'b1101_001?;
  localparam logic [7:0] MD_OP_SHCNT = 8'b1100_000?;
  localparam logic [7:0] MD_OP_AND_RM = 8'b0010_00??;
  localparam logic [7:0] MD_OP_GRP1 = 8'b1000_000?;
  localparam logic [7:0] MD_OP_AND_ACC = 8'b0010_010?;
  localparam logic [7:0] MD_OP_TEST_RM = 8'b1000_010?;
  localparam logic [7:0] MD_OP_TEST_ACC = 8'b1010_100?;
  localparam logic [7:0] MD_OP_OR_RM = 8'b0000_10??;
  localparam logic [7:0] MD_OP_OR_ACC = 8'b0000_110?;

  // ************************************************************
  // Field positions and ModRM reg codes
  // ************************************************************
  localparam int MD_W_BIT = 0;
  localparam int MD_D_BIT = 1;
  localparam int MD_S_BIT = 1;
  localparam int MD_MOD_HI = 7;
  localparam int MD_MOD_LO = 6;
  localparam int MD_REG_HI = 5;
  localparam int MD_REG_LO = 3;
  localparam int MD_RM_HI = 2;
  localparam logic [1:0] MD_MOD_REG = 2'h3;
  localparam logic [2:0] MD_G3_TEST = 3'h0;
  localparam logic [2:0] MD_G3_SMUL = 3'h5;
  localparam logic [2:0] MD_G3_UQUOT = 3'h6;
  localparam logic [2:0] MD_G3_SQUOT = 3'h7;
  localparam logic [2:0] MD_G1_OR = 3'h1;
  localparam logic [2:0] MD_G1_AND = 3'h4;

  // ************************************************************
  // Cycle tables, indexed {mem, word}: reg byte, reg word, mem byte, mem word
  // ************************************************************
  localparam int MD_CW = 7;
  typedef logic [MD_CW-1:0] md_cyc_t;
  localparam md_cyc_t MD_CYC_SMUL [4] = '{7'h1c, 7'h25, 7'h22, 7'h2b};
  localparam md_cyc_t MD_CYC_SIGNED_PRODUCT_IMM [4] = '{7'h19, 7'h19, 7'h20, 7'h20};
  localparam md_cyc_t MD_CYC_UQUOT [4] = '{7'h1d, 7'h26, 7'h23, 7'h2c};
  localparam md_cyc_t MD_CYC_SQUOT [4] = '{7'h34, 7'h3d, 7'h3a, 7'h43};
  localparam md_cyc_t MD_CYC_SH1 [4] = '{7'h02, 7'h02, 7'h0f, 7'h0f};
  localparam md_cyc_t MD_CYC_SHN [4] = '{7'h05, 7'h05, 7'h11, 7'h11};
  localparam md_cyc_t MD_CYC_LOG_RM [4] = '{7'h03, 7'h03, 7'h0a, 7'h0a};
  localparam md_cyc_t MD_CYC_LOG_IMM [4] = '{7'h04, 7'h04, 7'h10, 7'h10};
  localparam md_cyc_t MD_CYC_TEST_IMM [4] = '{7'h04, 7'h04, 7'h0a, 7'h0a};
  localparam md_cyc_t MD_CYC_ACC [4] = '{7'h03, 7'h04, 7'h03, 7'h04};
  localparam md_cyc_t MD_CYC_AAM = 7'h13;
  localparam md_cyc_t MD_CYC_AAD = 7'h0f;
  localparam md_cyc_t MD_CYC_CBW = 7'h02;
  localparam md_cyc_t MD_CYC_CWD = 7'h04;
  localparam md_cyc_t MD_CYC_NARROW_BUS = 7'h04;
  localparam int MD_NW = 10;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [4:0] {
    MD_K_NONE, MD_K_GRP3, MD_K_GRP1, MD_K_SMUL, MD_K_SIGNED_PRODUCT_IMM, MD_K_UQUOT,
    MD_K_SQUOT, MD_K_AAM, MD_K_AAD, MD_K_CBW, MD_K_CWD, MD_K_SH1, MD_K_SHCL,
    MD_K_SHCNT, MD_K_AND_RM, MD_K_AND_IMM, MD_K_AND_ACC, MD_K_TEST_RM,
    MD_K_TEST_IMM, MD_K_TEST_ACC, MD_K_OR_RM, MD_K_OR_IMM, MD_K_OR_ACC
  } md_kind_t;

  typedef enum logic [2:0] {
    MD_ROTATE_LEFT, MD_ROTATE_RIGHT, MD_ROTATE_CARRY_LEFT, MD_ROTATE_CARRY_RIGHT,
    MD_SHIFT_LEFT, MD_LOGICAL_SHIFT_RIGHT, MD_SHIFT_LEFT_ALT, MD_ARITH_SHIFT_RIGHT
  } md_shift_t;

  typedef struct packed {
    md_kind_t kind;
    logic word;
    logic dir;
    logic mem;
    logic [1:0] mode;
    logic [2:0] reg_f;
    logic [2:0] rm;
    md_shift_t shift_op_select;
    logic [7:0] shift_n;
    logic [15:0] imm;
    logic stores;
  } md_dec_t;

endpackage

/* design/md_cycle_rom.sv */
// Base cycle-count table with a registered read port
`timescale 1ns/100ps
`default_nettype none

module md_cycle_rom (
  input wire logic clock,
  input wire logic rst,
  input wire md_pkg::md_kind_t kind,
  input wire logic mem,
  input wire logic word,
  output logic [md_pkg::MD_CW-1:0] base_cycles
);

  logic [md_pkg::MD_CW-1:0] next_base_cycles;
  logic [1:0] idx;

  always_comb begin
    idx = {mem, word};
    case (kind)
      md_pkg::MD_K_SMUL: next_base_cycles = md_pkg::MD_CYC_SMUL[idx];
      md_pkg::MD_K_SIGNED_PRODUCT_IMM: next_base_cycles = md_pkg::MD_CYC_SIGNED_PRODUCT_IMM[idx];
      md_pkg::MD_K_UQUOT: next_base_cycles = md_pkg::MD_CYC_UQUOT[idx];
      md_pkg::MD_K_SQUOT: next_base_cycles = md_pkg::MD_CYC_SQUOT[idx];
      md_pkg::MD_K_AAM: next_base_cycles = md_pkg::MD_CYC_AAM;
      md_pkg::MD_K_AAD: next_base_cycles = md_pkg::MD_CYC_AAD;
      md_pkg::MD_K_CBW: next_base_cycles = md_pkg::MD_CYC_CBW;
      md_pkg::MD_K_CWD: next_base_cycles = md_pkg::MD_CYC_CWD;
      md_pkg::MD_K_SH1: next_base_cycles = md_pkg::MD_CYC_SH1[idx];
      md_pkg::MD_K_SHCL,
      md_pkg::MD_K_SHCNT: next_base_cycles = md_pkg::MD_CYC_SHN[idx];
      md_pkg::MD_K_AND_RM,
      md_pkg::MD_K_OR_RM,
      md_pkg::MD_K_TEST_RM: next_base_cycles = md_pkg::MD_CYC_LOG_RM[idx];
      md_pkg::MD_K_AND_IMM,
      md_pkg::MD_K_OR_IMM: next_base_cycles = md_pkg::MD_CYC_LOG_IMM[idx];
      md_pkg::MD_K_TEST_IMM: next_base_cycles = md_pkg::MD_CYC_TEST_IMM[idx];
      md_pkg::MD_K_AND_ACC,
      md_pkg::MD_K_OR_ACC,
      md_pkg::MD_K_TEST_ACC: next_base_cycles = md_pkg::MD_CYC_ACC[idx];
      default: next_base_cycles = md_pkg::MD_CYC_CBW;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      base_cycles <= '0;
    end else begin
      base_cycles <= next_base_cycles;
    end
  end

endmodule

`default_nettype wire

/* verif/md_decode_asserts.sv */
// Concurrent checks on the decoder's handshake and cycle counts
`timescale 1ns/100ps
`default_nettype none

module md_decode_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [7:0] shift_count_register,
  input wire logic narrow_bus,
  input wire logic byte_ready,
  input wire md_pkg::md_dec_t decoded,
  input wire logic exec_busy,
  input wire logic exec_done,
  input wire logic not_mine
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ************************************************************
  // Busy stretch length, held through the done pulse
  // ************************************************************
  logic [8:0] busy_len;
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_len <= 9'h000;
    end else if (exec_busy) begin
      busy_len <= busy_len + 9'h001;
    end else if (!exec_done) begin
      busy_len <= 9'h000;
    end
  end

  sequence s_busy_end;
    exec_busy ##1 !exec_busy;
  endsequence

  a_done_follows: assert property (s_busy_end |-> exec_done)
    else $error("done pulse missing after busy");
  a_done_pulse: assert property (exec_done |=> !exec_done)
    else $error("done longer than one cycle");
  a_ready_busy: assert property (exec_busy |-> !byte_ready)
    else $error("byte ready while busy");
  a_refuse_pulse: assert property (not_mine |=> !not_mine && !exec_busy)
    else $error("refusal not a lone pulse");
  a_busy_two: assert property ($rose(exec_busy) |-> exec_busy [*2])
    else $error("busy shorter than two cycles");
  a_byte_ext_len: assert property (exec_done && decoded.kind == md_pkg::MD_K_CBW
    |-> busy_len == 9'h002) else $error("byte extend length");
  a_pair_ext_len: assert property (exec_done && decoded.kind == md_pkg::MD_K_CWD
    |-> busy_len == 9'h004) else $error("pair extend length");
  a_bcd_prod_len: assert property (exec_done && decoded.kind == md_pkg::MD_K_AAM
    |-> busy_len == 9'h013) else $error("bcd product length");
  a_bcd_quot_len: assert property (exec_done && decoded.kind == md_pkg::MD_K_AAD
    |-> busy_len == 9'h00f) else $error("bcd quotient length");
  a_uquot_reg_len: assert property (exec_done && decoded.kind == md_pkg::MD_K_UQUOT
    && !decoded.mem |-> busy_len == (decoded.word ? 9'h026 : 9'h01d))
    else $error("unsigned quotient length");
endmodule

bind md_decode md_decode_asserts u_chk (
  .clock(clock), .rst(rst), .byte_valid(byte_valid), .byte_data(byte_data),
  .shift_count_register(shift_count_register), .narrow_bus(narrow_bus),
  .byte_ready(byte_ready), .decoded(decoded), .exec_busy(exec_busy),
  .exec_done(exec_done), .not_mine(not_mine)
);
`default_nettype wire

/* verif/muldiv_logic_opcode_decode_tb.sv */
// Self-checking testbench of the opcode decoder
`timescale 1ns/100ps
`default_nettype none

module muldiv_logic_opcode_decode_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic byte_valid = 1'b0;
  logic [7:0] byte_data = 8'h00;
  logic [7:0] shift_count_register = 8'h00;
  logic narrow_bus = 1'b0;
  logic byte_ready, exec_busy, exec_done, not_mine;
  md_pkg::md_dec_t decoded;
  int fail_count = 0;
  int n_checks = 0;

  always #5 clock = ~clock;

  md_decode u_dut (.clock(clock), .rst(rst), .byte_valid(byte_valid),
    .byte_data(byte_data), .shift_count_register(shift_count_register),
    .narrow_bus(narrow_bus), .byte_ready(byte_ready), .decoded(decoded),
    .exec_busy(exec_busy), .exec_done(exec_done), .not_mine(not_mine));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic fchk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // ************************************************************
  // Offers n bytes low first, each held until it is taken
  // ************************************************************
  task automatic issue(input int n, input logic [31:0] b);
    int t;
    for (int i = 0; i < n; i++) begin
      byte_valid = 1'b1;
      byte_data = b[8*i +: 8];
      t = 0;
      while (byte_ready !== 1'b1) begin
        tick(1);
        t++;
        if (t > 100) begin
          fchk(1'b0, "ready timeout");
          report_and_stop();
        end
      end
      tick(1);
    end
    byte_valid = 1'b0;
  endtask

  // Sends one instruction and counts its busy cycles; exp 0 expects a refusal
  task automatic chk(input int n, input logic [31:0] b, input int exp);
    int busy;
    int c;
    busy = 0;
    issue(n, b);
    for (c = 0; c < 400; c++) begin
      if (not_mine === 1'b1 || exec_done === 1'b1) break;
      if (exec_busy === 1'b1) busy++;
      tick(1);
    end
    if (c == 400) begin
      fchk(1'b0, "execution never ended");
      report_and_stop();
    end
    if (exp == 0) fchk(not_mine === 1'b1, "opcode not refused");
    else fchk(exec_done === 1'b1 && busy == exp, $sformatf("cycles %0d want %0d", busy, exp));
  endtask

  task automatic t_group3;
    chk(2, 32'he8f6, 28);
    fchk(decoded.kind === md_pkg::MD_K_SMUL && decoded.word === 1'b0, "byte product");
    chk(2, 32'he8f7, 37);
    chk(2, 32'h28f7, 43);
    fchk(decoded.mem === 1'b1 && decoded.word === 1'b1 && decoded.mode === 2'h0, "memory word");
    chk(2, 32'hf0f6, 29);
    chk(2, 32'hf0f7, 38);
    chk(2, 32'h30f6, 35);
    chk(2, 32'h30f7, 44);
    chk(2, 32'hf8f6, 52);
    chk(2, 32'hf8f7, 61);
    chk(2, 32'h38f6, 58);
    chk(2, 32'h38f7, 67);
    chk(3, 32'h7f_c0f6, 4);
    chk(4, 32'h1234_00f7, 10);
    fchk(decoded.imm === 16'h1234 && decoded.stores === 1'b0, "test immediate");
    chk(2, 32'hc8f6, 0);
  endtask

  task automatic t_bcd_ext;
    chk(2, 32'h0ad4, 19);
    chk(2, 32'h0ad5, 15);
    chk(2, 32'h0bd4, 0);
    chk(1, 32'h0098, 2);
    chk(1, 32'h0099, 4);
    chk(1, 32'h0090, 0);
  endtask

  task automatic t_shift;
    md_pkg::md_shift_t want [8] = '{md_pkg::MD_ROTATE_LEFT, md_pkg::MD_ROTATE_RIGHT,
      md_pkg::MD_ROTATE_CARRY_LEFT, md_pkg::MD_ROTATE_CARRY_RIGHT, md_pkg::MD_SHIFT_LEFT,
      md_pkg::MD_LOGICAL_SHIFT_RIGHT, md_pkg::MD_SHIFT_LEFT_ALT, md_pkg::MD_ARITH_SHIFT_RIGHT};
    for (int i = 0; i < 8; i++) begin
      chk(2, {16'h0000, 2'b11, i[2:0], 3'b000, 8'hd0}, 2);
      fchk(decoded.shift_op_select === want[i], "shift operation");
    end
    chk(2, 32'h00d1, 15);
    shift_count_register = 8'h03;
    chk(2, 32'he8d2, 8);
    chk(3, 32'h05_f8c0, 10);
    chk(3, 32'h07_10c1, 24);
    chk(3, 32'h00_c0c0, 5);
  endtask

  task automatic t_logic;
    chk(2, 32'hc020, 3);
    chk(2, 32'h0021, 10);
    chk(3, 32'h12_e080, 4);
    chk(4, 32'h1234_e081, 4);
    fchk(decoded.imm === 16'h1234 && decoded.kind === md_pkg::MD_K_AND_IMM, "and imm");
    chk(2, 32'h5524, 3);
    chk(3, 32'h3412_25, 4);
    chk(2, 32'hc084, 3);
    chk(2, 32'h55a8, 3);
    chk(3, 32'h3412_a9, 4);
    chk(2, 32'hc008, 3);
    chk(3, 32'h55_0880, 16);
    chk(4, 32'h1234_c881, 4);
    chk(2, 32'h550c, 3);
    chk(3, 32'h3412_0d, 4);
    chk(2, 32'hc080, 0);
  endtask

  task automatic t_imm_prod;
    chk(3, 32'h05_c06b, 25);
    fchk(decoded.imm === 16'h0005 && decoded.kind === md_pkg::MD_K_SIGNED_PRODUCT_IMM, "imm s");
    chk(4, 32'h1234_c069, 25);
    fchk(decoded.imm === 16'h1234, "imm word");
    chk(3, 32'h80_006b, 32);
    fchk(decoded.imm === 16'hff80, "imm sign");
  endtask

  task automatic t_narrow;
    narrow_bus = 1'b1;
    tick(3);
    chk(2, 32'h30f7, 48);
    chk(2, 32'h30f6, 35);
    chk(2, 32'h0021, 18);
    chk(2, 32'h0085, 14);
    chk(2, 32'h0023, 14);
    chk(3, 32'h80_006b, 32);
    chk(3, 32'h01_00c1, 18);
    narrow_bus = 1'b0;
    tick(3);
  endtask

  // A reset in mid-execution must drop busy and ready, then decode afresh
  task automatic t_reset_mid;
    issue(2, 32'hf8f7);
    tick(10);
    rst = 1'b1;
    tick(2);
    fchk(exec_busy === 1'b0 && byte_ready === 1'b0, "reset mid-run");
    rst = 1'b0;
    chk(1, 32'h0098, 2);
  endtask

  initial begin
    tick(20);
    fchk(byte_ready === 1'b0 && exec_busy === 1'b0, "reset outputs");
    rst = 1'b0;
    t_group3();
    t_bcd_ext();
    t_shift();
    t_logic();
    t_imm_prod();
    t_narrow();
    t_reset_mid();
    report_and_stop();
  end
endmodule
`default_nettype wire
